// file: verilog/dli_pkg.sv
/*
  Shared constants, state encodings and carrier structs of the debug link instruction engine.
  Assumes a byte-level half-duplex serial front end and a system-bus access layer outside.
*/
package dli_pkg;

  // ----------------------------------------
  // Instruction byte layout
  // ----------------------------------------
  localparam logic [2:0] OP_LDS = 3'h0;
  localparam logic [2:0] OP_LD = 3'h1;
  localparam logic [2:0] OP_STS = 3'h2;
  localparam logic [2:0] OP_ST = 3'h3;
  localparam logic [2:0] OP_CONTROL_STATUS_LOAD = 3'h4;
  localparam logic [2:0] OP_RPT = 3'h5;
  localparam logic [2:0] OP_CONTROL_STATUS_STORE = 3'h6;
  localparam logic [2:0] OP_KEY = 3'h7;
  localparam int OP_HI = 7, OP_LO = 5, SZA_HI = 3, SZA_LO = 2, SZB_HI = 1, SZB_LO = 0;
  localparam int PTR_HI = 3, PTR_LO = 2, CSA_HI = 3, KEY_SIB = 2, GT_HI = 2;
  localparam logic [1:0] PTR_IND = 2'h0, PTR_INC = 2'h1, PTR_REG = 2'h2;
  localparam logic [1:0] KSZ_64 = 2'h0, KSZ_128 = 2'h1;

  // ----------------------------------------
  // Lengths, characters and internal registers
  // ----------------------------------------
  localparam logic [4:0] ONE_BYTE = 5'h1, KEY_LEN = 5'h8, SIB64_LEN = 5'h8, SIB128_LEN = 5'h10;
  localparam logic [7:0] ACK_CHAR = 8'h40, RPT_MAX = 8'hFF;
  localparam logic [3:0] CS_CTRLA = 4'h2, CS_CRC = 4'h9;
  localparam logic [7:0] CTRLA_RST = 8'h02;

  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef enum logic [7:0] {
    S_IDLE = 8'h01, S_INSTR = 8'h02, S_ADDR = 8'h04, S_DATA = 8'h08,
    S_BUS = 8'h10, S_ACK = 8'h20, S_SEND = 8'h40, S_DONE = 8'h80
  } dli_state_e;

  typedef struct packed {
    logic req;
    logic write;
    logic [1:0] size;
    logic [31:0] addr;
    logic [31:0] wdata;
  } dli_bus_s;

  typedef struct packed {
    dli_state_e st;
    dli_state_e ret;
    logic [7:0] instr;
    logic [4:0] cnt;
    logic [4:0] len;
    logic [63:0] shift;
    logic [127:0] txBuf;
    logic [31:0] ptr;
    logic [7:0] rptCnt;
    dli_bus_s bus;
    logic [15:0][7:0] cs;
    logic [2:0] gtCnt;
    logic gateOpen;
    logic syncEvent;
    logic keyStrobe;
    logic [63:0] keyValue;
  } dli_eng_s;

endpackage

// file: verilog/dli_engine.sv
/*
  Instruction engine of the single-pin debug link, with its transmit FIFO.
  Assumes a serial front end delivering received bytes, sync and break strobes and a bit-time tick,
  and an access layer answering system-bus requests with a one-cycle acknowledge.
*/
// Function
// - Indirect load reads data space via pointer
// - Load response waits for guard time
// - Indirect load can return pointer itself
// - Pointer write with select 0x2, acknowledged
// - Select 0x0 writes, 0x1 also increments
// - Acknowledge after successful store bus write
// - Control-status load returns one internal byte
// - Control-status store writes, sends nothing
// - Repeat runs next instruction count+1 times
// - Repeated iterations carry no sync/instruction
// - Repeat instruction itself never repeats
// - Break or a bus error cancels an ongoing repeat
// - Repeated loads except LDS stream, guard only first
// - Keys 64 bits, info block up to 128
// - Key silent; info block sent after guard
// - Boot CRC result readable in status space
// - Each received sync emits an event
// - Configurable idle bits before first response
`timescale 1ns/10ps

module dli_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Fill side
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  // Drain side
  input wire logic drainEnable,
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [CW-1:0] count;
    logic outValid;
    logic [WIDTH-1:0] outData;
  } dli_fifo_s;

  dli_fifo_s f;
  dli_fifo_s next_f;
  logic push;
  logic refill;

  function automatic logic [AW-1:0] wrap_inc(input logic [AW-1:0] p);
    wrap_inc = (p == AW'(DEPTH - 1)) ? '0 : p + AW'(1);
  endfunction

  assign inReady = f.count < CW'(DEPTH);
  assign outValid = f.outValid;
  assign outData = f.outData;

  always_comb begin
    next_f = f;
    push = inValid && inReady;
    refill = drainEnable && (f.count != '0) && (!f.outValid || outReady);
    if (push) begin
      next_f.mem[f.wp] = inData;
      next_f.wp = wrap_inc(f.wp);
    end
    if (f.outValid && outReady) begin
      next_f.outValid = 1'b0;
    end
    if (refill) begin
      next_f.outData = f.mem[f.rp];
      next_f.outValid = 1'b1;
      next_f.rp = wrap_inc(f.rp);
    end
    next_f.count = f.count + CW'(push) - CW'(refill);
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      f <= '0;
    end else begin
      f <= next_f;
    end
  end
endmodule

module dli_engine #(
  parameter int FIFO_DEPTH = 8
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Serial front end
  input wire logic rxValid,
  input wire logic [7:0] rxData,
  input wire logic syncRx,
  input wire logic breakRx,
  input wire logic bitTick,
  output logic txValid,
  input wire logic txReady,
  output logic [7:0] txData,
  // System bus access layer
  output dli_pkg::dli_bus_s bus,
  input wire logic busAck,
  input wire logic busErr,
  input wire logic [31:0] busRdata,
  // Device side
  input wire logic [7:0] bootCrcResult,
  input wire logic [127:0] sibData,
  output logic syncEvent,
  output logic keyStrobe,
  output logic [63:0] keyValue
);
  import dli_pkg::*;

  dli_eng_s eng;
  dli_eng_s next_eng;
  logic pushValid;
  logic pushReady;
  logic [7:0] pushData;
  logic [2:0] op;
  logic [1:0] ptrSel;
  logic [1:0] szB;
  logic [3:0] csa;

  assign op = eng.instr[OP_HI:OP_LO];
  assign ptrSel = eng.instr[PTR_HI:PTR_LO];
  assign szB = eng.instr[SZB_HI:SZB_LO];
  assign csa = eng.instr[CSA_HI:0];
  assign bus = eng.bus;
  assign syncEvent = eng.syncEvent;
  assign keyStrobe = eng.keyStrobe;
  assign keyValue = eng.keyValue;

  // ----------------------------------------
  // Decoding
  // ----------------------------------------
  function automatic logic [4:0] size_len(input logic [1:0] sz);
    size_len = {3'h0, sz} + ONE_BYTE;
  endfunction

  function automatic dli_eng_s start_instr(input dli_eng_s s, input logic [7:0] crc, input logic [127:0] system_info_block);
    dli_eng_s n;
    logic [1:0] sb;
    logic [3:0] ca;
    n = s;
    sb = s.instr[SZB_HI:SZB_LO];
    ca = s.instr[CSA_HI:0];
    n.cnt = '0;
    n.shift = '0;
    n.ret = S_DONE;
    case (s.instr[OP_HI:OP_LO])
      OP_LDS, OP_STS: begin
        n.st = S_ADDR;
        n.len = size_len(s.instr[SZA_HI:SZA_LO]);
      end
      OP_LD: begin
        if (s.instr[PTR_HI:PTR_LO] == PTR_REG) begin
          n.txBuf = {96'h0, s.ptr};
          n.len = size_len(sb);
          n.st = S_SEND;
        end else begin
          n.bus.req = 1'b1;
          n.bus.write = 1'b0;
          n.bus.addr = s.ptr;
          n.bus.size = sb;
          n.st = S_BUS;
        end
      end
      OP_ST: begin
        n.st = S_DATA;
        n.len = size_len(sb);
      end
      OP_CONTROL_STATUS_LOAD: begin
        n.txBuf = {120'h0, (ca == CS_CRC) ? crc : s.cs[ca]};
        n.len = ONE_BYTE;
        n.st = S_SEND;
      end
      OP_CONTROL_STATUS_STORE: begin
        n.st = S_DATA;
        n.len = ONE_BYTE;
      end
      OP_RPT: begin
        n.st = S_DATA;
        n.len = size_len(sb);
      end
      default: begin
        if (s.instr[KEY_SIB]) begin
          n.txBuf = system_info_block;
          n.len = (sb == KSZ_128) ? SIB128_LEN : SIB64_LEN;
          n.st = S_SEND;
        end else if (sb == KSZ_64) begin
          n.st = S_DATA;
          n.len = KEY_LEN;
        end else begin
          n.st = S_DONE;
        end
      end
    endcase
    return n;
  endfunction

  // ----------------------------------------
  // Sequencing
  // ----------------------------------------
  always_comb begin
    next_eng = eng;
    pushValid = 1'b0;
    pushData = ACK_CHAR;
    next_eng.syncEvent = syncRx;
    next_eng.keyStrobe = 1'b0;
    if (rxValid) begin
      next_eng.gateOpen = 1'b0;
      next_eng.gtCnt = '0;
    end else if (!eng.gateOpen && eng.gtCnt == eng.cs[CS_CTRLA][GT_HI:0]) begin
      next_eng.gateOpen = 1'b1;
    end else if (!eng.gateOpen && bitTick) begin
      next_eng.gtCnt = eng.gtCnt + 3'h1;
    end
    case (eng.st)
      S_IDLE: begin
        if (syncRx) begin
          next_eng.st = S_INSTR;
        end
      end
      S_INSTR: begin
        if (rxValid) begin
          next_eng.instr = rxData;
          next_eng = start_instr(next_eng, bootCrcResult, sibData);
        end
      end
      S_ADDR: begin
        if (rxValid) begin
          next_eng.shift[{eng.cnt[2:0], 3'h0} +: 8] = rxData;
          next_eng.cnt = eng.cnt + 5'h1;
          if (eng.cnt == eng.len - 5'h1) begin
            next_eng.cnt = '0;
            next_eng.bus.addr = next_eng.shift[31:0];
            next_eng.bus.size = szB;
            if (op == OP_LDS) begin
              next_eng.bus.req = 1'b1;
              next_eng.bus.write = 1'b0;
              next_eng.st = S_BUS;
            end else begin
              next_eng.len = size_len(szB);
              next_eng.ret = S_DATA;
              next_eng.st = S_ACK;
            end
          end
        end
      end
      S_DATA: begin
        if (rxValid) begin
          next_eng.shift[{eng.cnt[2:0], 3'h0} +: 8] = rxData;
          next_eng.cnt = eng.cnt + 5'h1;
          if (eng.cnt == eng.len - 5'h1) begin
            next_eng.cnt = '0;
            next_eng.ret = S_DONE;
            next_eng.st = S_DONE;
            case (op)
              OP_ST, OP_STS: begin
                if (op == OP_ST && ptrSel == PTR_REG) begin
                  next_eng.ptr = next_eng.shift[31:0];
                  next_eng.st = S_ACK;
                end else begin
                  next_eng.bus.req = 1'b1;
                  next_eng.bus.write = 1'b1;
                  next_eng.bus.wdata = next_eng.shift[31:0];
                  next_eng.bus.size = szB;
                  next_eng.st = S_BUS;
                  if (op == OP_ST) begin
                    next_eng.bus.addr = eng.ptr;
                  end
                end
              end
              OP_CONTROL_STATUS_STORE: begin
                next_eng.cs[csa] = rxData;
              end
              OP_RPT: begin
                next_eng.rptCnt = (|next_eng.shift[63:8]) ? RPT_MAX : next_eng.shift[7:0];
              end
              default: begin
                next_eng.keyValue = next_eng.shift;
                next_eng.keyStrobe = 1'b1;
              end
            endcase
          end
        end
      end
      S_BUS: begin
        if (busAck) begin
          next_eng.bus.req = 1'b0;
          if (busErr) begin
            next_eng.st = S_IDLE;
            next_eng.rptCnt = '0;
          end else begin
            if ((op == OP_ST || op == OP_LD) && ptrSel == PTR_INC) begin
              next_eng.ptr = eng.ptr + {30'h0, szB} + 32'h1;
            end
            if (eng.bus.write) begin
              next_eng.ret = S_DONE;
              next_eng.st = S_ACK;
            end else begin
              next_eng.txBuf = {96'h0, busRdata};
              next_eng.len = size_len(szB);
              next_eng.cnt = '0;
              next_eng.st = S_SEND;
            end
          end
        end
      end
      S_ACK: begin
        pushValid = 1'b1;
        if (pushReady) begin
          next_eng.st = eng.ret;
        end
      end
      S_SEND: begin
        pushValid = 1'b1;
        pushData = eng.txBuf[7:0];
        if (pushReady) begin
          next_eng.txBuf = eng.txBuf >> 8;
          next_eng.cnt = eng.cnt + 5'h1;
          if (eng.cnt == eng.len - 5'h1) begin
            next_eng.st = S_DONE;
          end
        end
      end
      S_DONE: begin
        if (op != OP_RPT && eng.rptCnt != '0) begin
          next_eng.rptCnt = eng.rptCnt - 8'h1;
          next_eng = start_instr(next_eng, bootCrcResult, sibData);
        end else begin
          next_eng.st = S_IDLE;
        end
      end
      default: begin
        next_eng.st = S_IDLE;
      end
    endcase
    if (breakRx) begin
      next_eng.st = S_IDLE;
      next_eng.rptCnt = '0;
      next_eng.bus.req = 1'b0;
      pushValid = 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      eng <= '0;
      eng.st <= S_IDLE;
      eng.ret <= S_DONE;
      eng.gateOpen <= 1'b1;
      eng.cs[CS_CTRLA] <= CTRLA_RST;
    end else begin
      eng <= next_eng;
    end
  end

  // ----------------------------------------
  // Transmit buffer
  // ----------------------------------------
  dli_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) txFifo (
    .clock(clock),
    .rst_n(rst_n),
    .inValid(pushValid),
    .inReady(pushReady),
    .inData(pushData),
    .drainEnable(eng.gateOpen),
    .outValid(txValid),
    .outReady(txReady),
    .outData(txData)
  );

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  sequence busOkWrite;
    eng.st == S_BUS && busAck && !busErr && eng.bus.write && !breakRx;
  endsequence

  sequence ackPushed;
    eng.st == S_ACK && pushValid && pushData == ACK_CHAR;
  endsequence

  AST_SYNC_EVENT: assert property (syncRx |=> syncEvent) else $error("sync event missing");
  AST_GUARD_FIRST: assert property ($rose(txValid) |-> $past(eng.gateOpen)) else $error("sent inside guard");
  AST_GUARD_CLOSE: assert property (rxValid |=> !eng.gateOpen ##0 eng.gtCnt == 3'h0)
    else $error("guard not restarted");
  AST_STORE_ACK: assert property (busOkWrite |=> ackPushed) else $error("store not acknowledged");
  AST_PTR_INC: assert property (busOkWrite ##0 (op == OP_ST && ptrSel == PTR_INC)
    |=> eng.ptr == $past(eng.ptr) + {30'h0, $past(szB)} + 32'h1) else $error("pointer not advanced");
  AST_PTR_WRITE: assert property (eng.st == S_DATA && rxValid && !breakRx && op == OP_ST && ptrSel == PTR_REG
    && eng.cnt == eng.len - 5'h1 |=> ackPushed) else $error("pointer write not acknowledged");
  AST_CONTROL_STATUS_STORE_SILENT: assert property (eng.st == S_DATA && rxValid && !breakRx && op == OP_CONTROL_STATUS_STORE
    |=> eng.st == S_DONE ##1 eng.st != S_ACK && eng.st != S_SEND) else $error("control store answered");
  AST_CONTROL_STATUS_LOAD_ONE: assert property (eng.st == S_INSTR && rxValid && !breakRx && rxData[OP_HI:OP_LO] == OP_CONTROL_STATUS_LOAD
    |=> eng.st == S_SEND && eng.len == ONE_BYTE) else $error("control load not one byte");
  AST_RPT_DEC: assert property (eng.st == S_DONE && op != OP_RPT && eng.rptCnt != 8'h0 && !breakRx
    |=> eng.rptCnt == $past(eng.rptCnt) - 8'h1 && eng.st != S_IDLE) else $error("repeat not counted");
  AST_RPT_SELF: assert property (eng.st == S_DONE && op == OP_RPT |=> eng.st == S_IDLE)
    else $error("repeat instruction repeated");
  AST_BREAK: assert property (breakRx |=> eng.st == S_IDLE && eng.rptCnt == 8'h0 && !bus.req)
    else $error("break did not cancel");
endmodule

// file: bench/dli_host_model.sv
/*
  Host-side model of the debugger and its serial front end: bit timing, byte intake with optional stalls.
  Assumes the engine offers response bytes by valid/ready and receives bytes from the bench.
*/
`timescale 1ns/10ps

module dli_host_model (
  // Clock
  input wire logic clock,
  // Serial front end
  input wire logic rxValid,
  input wire logic txValid,
  input wire logic [7:0] txData,
  input wire logic slow,
  output logic txReady,
  output logic bitTick
);
  logic [2:0] phase = 3'h0;
  logic [7:0] gap = 8'h00;
  logic [7:0] firstGap = 8'h00;
  logic rxSeen = 1'b0;
  logic [7:0] got[$];

  initial begin
    txReady = 1'b0;
    bitTick = 1'b0;
  end

  // ----------------------------------------
  // Bit timing, stalls and byte intake
  // ----------------------------------------
  always @(posedge clock) begin
    phase <= phase + 3'h1;
    bitTick <= (phase[1:0] == 2'h3);
    txReady <= slow ? (phase == 3'h7) : 1'b1;
    if (rxValid) begin
      gap <= 8'h00;
      rxSeen <= 1'b1;
    end else if (bitTick) begin
      gap <= gap + 8'h01;
    end
    if (txValid && txReady) begin
      got.push_back(txData);
      if (rxSeen) begin
        firstGap <= gap;
        rxSeen <= 1'b0;
      end
    end
  end
endmodule

// file: bench/debug_link_instruction_engine_tb_top.sv
/*
  Self-checking bench of the debug link instruction engine, with a memory model of the access layer.
  Assumes the host model in its own file and the engine's byte-level front-end contract.
*/
`timescale 1ns/10ps

module debug_link_instruction_engine_tb_top;
  import dli_pkg::*;
  logic clock = 1'b0, rst_n = 1'b0, rxValid = 1'b0, syncRx = 1'b0, breakRx = 1'b0;
  logic busAck = 1'b0, busErr = 1'b0, slow = 1'b0;
  logic [7:0] rxData = 8'h00, bootCrcResult = 8'h5C;
  logic [31:0] busRdata = 32'h0000_0000;
  logic [127:0] sibData = 128'hF0E1_D2C3_B4A5_9687_7869_5A4B_3C2D_1E0F;
  logic txValid, txReady, bitTick, syncEvent, keyStrobe;
  logic [7:0] txData;
  logic [63:0] keyValue;
  dli_bus_s bus;
  logic [7:0] mem [0:255];
  int dly = 0, nMismatch = 0, checks = 0, keyPulses = 0;

  // ----------------------------------------
  // Clock, engine, host and access layer
  // ----------------------------------------
  initial begin
    forever #2 clock = ~clock;
  end

  dli_engine #(.FIFO_DEPTH(8)) dut_u (.clock(clock), .rst_n(rst_n), .rxValid(rxValid), .rxData(rxData),
    .syncRx(syncRx), .breakRx(breakRx), .bitTick(bitTick), .txValid(txValid), .txReady(txReady),
    .txData(txData), .bus(bus), .busAck(busAck), .busErr(busErr), .busRdata(busRdata),
    .bootCrcResult(bootCrcResult), .sibData(sibData), .syncEvent(syncEvent), .keyStrobe(keyStrobe),
    .keyValue(keyValue));

  dli_host_model host_u (.clock(clock), .rxValid(rxValid), .txValid(txValid), .txData(txData),
    .slow(slow), .txReady(txReady), .bitTick(bitTick));

  initial begin
    for (int i = 0; i < 256; i++) mem[i] = 8'(i) ^ 8'h3C;
  end

  always @(posedge clock) begin
    if (keyStrobe) keyPulses <= keyPulses + 1;
  end

  always @(posedge clock) begin
    busAck <= 1'b0;
    if (bus.req && !busAck) begin
      dly <= dly + 1;
      if (dly == 2) begin
        dly <= 0;
        busAck <= 1'b1;
        busRdata <= {mem[bus.addr[7:0] + 8'h03], mem[bus.addr[7:0] + 8'h02], mem[bus.addr[7:0] + 8'h01],
          mem[bus.addr[7:0]]};
        if (bus.write) begin
          for (int i = 0; i <= int'(bus.size); i++) mem[bus.addr[7:0] + 8'(i)] <= bus.wdata[8*i+:8];
        end
      end
    end
  end

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic check(input logic [127:0] seen, input logic [127:0] exp);
    checks++;
    if (seen !== exp) begin
      nMismatch++;
      $display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  task automatic final_report;
    $display("Mismatches %0d, comparisons %0d", nMismatch, checks);
    if (nMismatch == 0 && checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  task automatic send(input logic [7:0] b);
    @(posedge clock);
    rxValid <= 1'b1;
    rxData <= b;
    @(posedge clock);
    rxValid <= 1'b0;
    repeat (8) @(posedge clock);
  endtask

  task automatic sync;
    @(posedge clock);
    syncRx <= 1'b1;
    @(posedge clock);
    syncRx <= 1'b0;
    #1 check(syncEvent, 1'b1);
    repeat (4) @(posedge clock);
  endtask

  task automatic recv(input logic [7:0] exp);
    for (int i = 0; i < 600 && host_u.got.size() == 0; i++) @(posedge clock);
    #1;
    if (host_u.got.size() == 0) begin
      check(1'b0, 1'b1);
      final_report();
    end
    check(host_u.got.pop_front(), exp);
  endtask

  task automatic silent;
    repeat (80) @(posedge clock);
    check(host_u.got.size(), 0);
  endtask

  task automatic set_ptr(input logic [31:0] p);
    sync();
    send(8'h6B);
    for (int i = 0; i < 4; i++) send(p[8*i+:8]);
    recv(ACK_CHAR);
  endtask

  task automatic get_ptr(input logic [31:0] p);
    sync();
    send(8'h2B);
    for (int i = 0; i < 4; i++) recv(p[8*i+:8]);
  endtask

  task automatic store(input logic [7:0] ins, input logic [7:0] d);
    sync();
    send(ins);
    send(d);
    recv(ACK_CHAR);
  endtask

  task automatic start_repeat(input logic [7:0] n, input logic [7:0] ins);
    sync();
    send(8'hA0);
    send(n);
    sync();
    send(ins);
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic sc_ctrl;
    sync();
    send(8'h82);
    recv(8'h02);
    check(host_u.firstGap >= 8'h02, 1'b1);
    sync();
    send(8'hC2);
    send(8'h03);
    silent();
    sync();
    send(8'h82);
    recv(8'h03);
    check(host_u.firstGap >= 8'h03, 1'b1);
    sync();
    send(8'h89);
    recv(bootCrcResult);
  endtask

  task automatic sc_store;
    set_ptr(32'h0000_0010);
    get_ptr(32'h0000_0010);
    store(8'h60, 8'h5A);
    check(mem[8'h10], 8'h5A);
    get_ptr(32'h0000_0010);
    store(8'h64, 8'hA5);
    check(mem[8'h10], 8'hA5);
    get_ptr(32'h0000_0011);
    sync();
    send(8'h23);
    for (int i = 0; i < 4; i++) recv((8'h11 + 8'(i)) ^ 8'h3C);
  endtask

  task automatic sc_repeat;
    start_repeat(8'h02, 8'h64);
    for (int i = 1; i < 4; i++) begin
      send(8'(i * 17));
      recv(ACK_CHAR);
    end
    for (int i = 1; i < 4; i++) check(mem[8'h10 + 8'(i)], 8'(i * 17));
    get_ptr(32'h0000_0014);
    set_ptr(32'h0000_0011);
    start_repeat(8'h02, 8'h24);
    for (int i = 1; i < 4; i++) recv(8'(i * 17));
    get_ptr(32'h0000_0014);
  endtask

  task automatic sc_break;
    start_repeat(8'h03, 8'h64);
    send(8'h77);
    recv(ACK_CHAR);
    @(posedge clock);
    breakRx <= 1'b1;
    @(posedge clock);
    breakRx <= 1'b0;
    send(8'h88);
    silent();
    check(mem[8'h15], 8'h15 ^ 8'h3C);
    get_ptr(32'h0000_0015);
  endtask

  task automatic sc_key;
    sync();
    send(8'hE0);
    for (int i = 0; i < 8; i++) send(8'(i + 1));
    check(keyValue, 64'h0807_0605_0403_0201);
    check(keyPulses, 1);
    silent();
    slow <= 1'b1;
    sync();
    send(8'hE5);
    for (int i = 0; i < 16; i++) recv(sibData[8*i+:8]);
    slow <= 1'b0;
  endtask

  task automatic sc_direct;
    start_repeat(8'h01, 8'h40);
    for (int i = 0; i < 2; i++) begin
      send(8'h30 + 8'(i));
      recv(ACK_CHAR);
      send(8'hC0 + 8'(i));
      recv(ACK_CHAR);
    end
    for (int i = 0; i < 2; i++) check(mem[8'h30 + 8'(i)], 8'hC0 + 8'(i));
    start_repeat(8'h01, 8'h00);
    for (int i = 0; i < 2; i++) begin
      send(8'h30 + 8'(i));
      recv(8'hC0 + 8'(i));
    end
  endtask

  initial begin
    repeat (3) @(posedge clock);
    rst_n <= 1'b1;
    sc_ctrl();
    sc_direct();
    sc_store();
    sc_repeat();
    sc_break();
    sc_key();
    final_report();
  end
endmodule
